/* hdl/arcz_zone_logic.sv */
// Arc fault zone decision logic: sensor channels, current stages, zones.
// Assumes sensor pins and the binary input are asynchronous; all other inputs
// come from logic on sys_clk.
//
// Notes on behaviour
// [RL1] Four sensor channels, up to three sensors each, each evaluated on its own.
// [RL2] Channel light output is high while that channel sees light.
// [RL3] Channel pressure output is high while that channel's sensor reports pressure.
// [RL4] Binary-input output is high while the arc card binary input is energized.
// [RL5] Phase or residual start output high when that current exceeds its limit.
// [RL6] Active block on a current stage gives its blocked output instead of start.
// [RL7] Enabled zone trips on light alone, or light with an enabled current.
// [RL8] Zone conditions met while the zone block is active: blocked, not trip.
// [RL9] Channel sensor fault when detected sensor count differs from configured count.
// [RL10] Remote unit fault when connected unit count differs from configured count.
// [RL11] With a current enabled, light and overcurrent must hold together.
// [RL12] Current condition needs a required number of samples above the limit.
// [RL13] Samples for three phase and two residual channels on a 5 ms base.
// [RL14] Current condition from phases, residuals, or both, as configured.
// [RL15] Each zone enabled separately; each channel's light mapped to any zones.
// [RL16] Pressure and current enabled per zone like the light inputs.
// [RL17] Remote units send periodic test pulses on the interconnect wiring.
// [RL18] Test pulse option keeps remote unit pulses off the binary input.
// [RL19] Fast trip outputs carry overcurrent and master trip to remote units.
// [RL20] Four zone enables, default disabled; disabled zone never trips or blocks.
// [RL21] Configured sensor count is zero to three, default zero.
// [RL22] Residual source none, first or second channel; default none.
// [RL23] Pick-up limits 0.05 to 40.00 per-unit in 0.01 steps, default 1.2.
// [RL24] All outputs re-evaluated once per 5 ms and updated at its end.
// [RL25] Zone trip and blocked are not latched; they drop within one period.
`timescale 1ns/10ps
module arcz_zone_logic
#(
  parameter int EVAL_CYC = arcz_pkg::EVAL_PERIOD_CYC
)
(
  // Clock and reset
  input  wire logic                                             sys_clk,
  input  wire logic                                             sys_rst,
  input  wire logic                                             clk_en,
  // Configuration, taken on cfg_load
  input  wire logic                                             cfg_load,
  input  wire arcz_pkg::arcz_cfg_t                              cfg_in,
  // Sensor and binary input pins
  input  wire logic [arcz_pkg::NUM_CHAN-1:0]                    light_pin,
  input  wire logic [arcz_pkg::NUM_CHAN-1:0]                    pressure_pin,
  input  wire logic                                             arc_card_binary_input,
  // Sensor presence from the front end
  input  wire logic [arcz_pkg::NUM_CHAN-1:0][1:0]               sensor_detected,
  input  wire logic [arcz_pkg::UNIT_CNT_W-1:0]                  units_connected,
  // Current samples
  input  wire logic                                             sample_valid,
  input  wire logic [arcz_pkg::NUM_PHASE-1:0][arcz_pkg::SAMPLE_W-1:0] phase_sample,
  input  wire logic [arcz_pkg::SAMPLE_W-1:0]                    residual_current_first,
  input  wire logic [arcz_pkg::SAMPLE_W-1:0]                    residual_current_second,
  // Blocking inputs
  input  wire logic                                             phase_block,
  input  wire logic                                             resid_block,
  input  wire logic [arcz_pkg::NUM_ZONE-1:0]                    zone_block,
  // Results
  output      arcz_pkg::arcz_stat_t                             status,
  output      logic                                             fast_trip_output_a,
  output      logic                                             fast_trip_output_b,
  output      logic                                             eval_done
);

  localparam int NCUR = arcz_pkg::NUM_PHASE + 2;

  arcz_pkg::arcz_cfg_t               cfg;
  arcz_pkg::arcz_stat_t              next_status;
  logic [arcz_pkg::EVAL_CNT_W-1:0]   eval_cnt;
  logic                              eval_tick;
  logic [arcz_pkg::NUM_CHAN-1:0]     light_meta;
  logic [arcz_pkg::NUM_CHAN-1:0]     light_sync;
  logic [arcz_pkg::NUM_CHAN-1:0]     press_meta;
  logic [arcz_pkg::NUM_CHAN-1:0]     press_sync;
  logic                              bi_meta;
  logic                              bi_sync;
  logic [arcz_pkg::FILT_CNT_W-1:0]   bi_cnt;
  logic                              bi_filt;
  logic [NCUR-1:0][arcz_pkg::SAMPLE_W-1:0] cur_sample;
  logic [NCUR-1:0][arcz_pkg::LIMIT_W-1:0]  cur_limit;
  logic [NCUR-1:0]                   cur_over;
  logic                              phase_over;
  logic                              resid_over;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Held locally so the settings have defined defaults after reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cfg <= arcz_pkg::CFG_RESET;                           // [RL20] [RL21] [RL22] [RL23]
    else if (clk_en && cfg_load)
      cfg <= cfg_in;
  end

  // ----------------------------------------------------------------
  // Evaluation period
  // ----------------------------------------------------------------
  assign eval_tick = (eval_cnt == arcz_pkg::EVAL_CNT_W'(EVAL_CYC - 1));

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      eval_cnt <= '0;
    else if (clk_en)
      eval_cnt <= eval_tick ? '0 : eval_cnt + 20'h00001;     // [RL24]
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      light_meta <= '0;
      light_sync <= '0;
      press_meta <= '0;
      press_sync <= '0;
      bi_meta    <= 1'b0;
      bi_sync    <= 1'b0;
    end
    else if (clk_en)
    begin
      light_meta <= light_pin;
      light_sync <= light_meta;
      press_meta <= pressure_pin;
      press_sync <= press_meta;
      bi_meta    <= arc_card_binary_input;
      bi_sync    <= bi_meta;
    end
  end

  // ----------------------------------------------------------------
  // Binary input test pulse suppression
  // ----------------------------------------------------------------
  // Remote units pulse the wiring to prove it; with the option on, only a
  // level held longer than the filter counts. Costs that much binary_in output latency.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bi_cnt  <= '0;
      bi_filt <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!bi_sync)
      begin
        bi_cnt  <= '0;
        bi_filt <= 1'b0;
      end
      else if (!cfg.test_pulse_en)
        bi_filt <= 1'b1;                                    // [RL4]
      else if (bi_cnt < arcz_pkg::FILT_CNT_W'(arcz_pkg::PULSE_FILT_CYC))
        bi_cnt <= bi_cnt + 12'h001;                         // [RL17] [RL18]
      else
        bi_filt <= 1'b1;                                    // [RL18]
    end
  end

  // ----------------------------------------------------------------
  // Current stages
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < arcz_pkg::NUM_PHASE; i++)
    begin
      cur_sample[i] = phase_sample[i];
      cur_limit[i]  = cfg.phase_limit;
    end
    cur_sample[arcz_pkg::NUM_PHASE]   = residual_current_first;
    cur_sample[arcz_pkg::NUM_PHASE+1] = residual_current_second;
    cur_limit[arcz_pkg::NUM_PHASE]    = cfg.resid_limit;
    cur_limit[arcz_pkg::NUM_PHASE+1]  = cfg.resid_limit;
  end

  for (genvar g = 0; g < NCUR; g++)
  begin : g_cur
    arcz_over_det u_det                                     // [RL12] [RL13]
    (
      .sys_clk      (sys_clk),
      .sys_rst      (sys_rst),
      .clk_en       (clk_en),
      .sample_valid (sample_valid),
      .sample       (cur_sample[g]),
      .limit        (cur_limit[g]),
      .over         (cur_over[g])
    );
  end

  assign phase_over = |cur_over[arcz_pkg::NUM_PHASE-1:0];

  always_comb
  begin
    case (cfg.res_src)                                      // [RL22]
      arcz_pkg::RES_FIRST:  resid_over = cur_over[arcz_pkg::NUM_PHASE];
      arcz_pkg::RES_SECOND: resid_over = cur_over[arcz_pkg::NUM_PHASE+1];
      default:              resid_over = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next evaluation result
  // ----------------------------------------------------------------
  always_comb
  begin
    logic sensed;
    logic cur_ok;
    logic cur_any;
    sensed  = 1'b0;
    cur_ok  = 1'b0;
    cur_any = 1'b0;
    next_status               = arcz_pkg::STAT_RESET;
    next_status.light         = light_sync;                 // [RL1] [RL2]
    next_status.pressure      = press_sync;                 // [RL3]
    next_status.binary_in     = bi_filt;                    // [RL4]
    next_status.phase_start   = phase_over && !phase_block; // [RL5] [RL6]
    next_status.resid_start   = resid_over && !resid_block; // [RL5] [RL6]
    next_status.phase_blocked = phase_over && phase_block;  // [RL6]
    next_status.resid_blocked = resid_over && resid_block;  // [RL6]
    for (int c = 0; c < arcz_pkg::NUM_CHAN; c++)
      next_status.sensor_fault[c] = sensor_detected[c] != cfg.sensor_count[c]; // [RL9]
    next_status.unit_fault = units_connected != cfg.unit_count;               // [RL10]
    for (int z = 0; z < arcz_pkg::NUM_ZONE; z++)
    begin
      sensed  = |(light_sync & cfg.light_map[z]) | |(press_sync & cfg.press_map[z]); // [RL15] [RL16]
      cur_any = cfg.phase_en[z] || cfg.resid_en[z];                                  // [RL14] [RL16]
      cur_ok  = (cfg.phase_en[z] && next_status.phase_start)
                || (cfg.resid_en[z] && next_status.resid_start);
      if (cfg.zone_en[z] && sensed && (!cur_any || cur_ok))  // [RL7] [RL11] [RL20]
      begin
        next_status.zone_trip[z]    = !zone_block[z];        // [RL8]
        next_status.zone_blocked[z] = zone_block[z];         // [RL8]
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Outputs are rebuilt from scratch every period, so nothing latches
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status             <= arcz_pkg::STAT_RESET;
      fast_trip_output_a <= 1'b0;
      fast_trip_output_b <= 1'b0;
      eval_done          <= 1'b0;
    end
    else if (clk_en)
    begin
      eval_done <= eval_tick;
      if (eval_tick)
      begin
        status             <= next_status;                  // [RL24] [RL25]
        fast_trip_output_a <= next_status.phase_start || next_status.resid_start; // [RL19]
        fast_trip_output_b <= |next_status.zone_trip;                              // [RL19]
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_zone_enable_gate: assert property (clk_en && eval_tick |=> // [RL20]
                                       ((status.zone_trip | status.zone_blocked) & ~$past(cfg.zone_en)) == '0)
    else $error("Disabled zone shows trip or blocked");

  a_trip_block_excl: assert property ((status.zone_trip & status.zone_blocked) == '0) // [RL8]
    else $error("Zone trip and blocked both high");

  a_hold_between: assert property (clk_en && !eval_tick |=> $stable(status)) // [RL24]
    else $error("Outputs changed outside an evaluation");

  a_fault_compare: assert property (clk_en && eval_tick |=> status.sensor_fault == $past(next_status.sensor_fault)
                                    && status.unit_fault == $past(units_connected != cfg.unit_count)) // [RL9]
    else $error("Fault flags do not follow the count compare");

  a_start_block_excl: assert property (!(status.phase_start && status.phase_blocked)
                                       && !(status.resid_start && status.resid_blocked)) // [RL6]
    else $error("Current stage started and blocked together");

  a_light_update: assert property (clk_en && eval_tick |=> status.light == $past(light_sync)) // [RL2]
    else $error("Light output missed the synchronised light level");

  a_trip_needs_light: assert property (clk_en && eval_tick && !(|light_sync) && !(|press_sync)
                                       |=> status.zone_trip == '0) // [RL7]
    else $error("Zone tripped without light or pressure");

  a_zone_drops: assert property (clk_en && eval_tick && next_status.zone_trip == '0
                                 |=> status.zone_trip == '0 && !fast_trip_output_b) // [RL25]
    else $error("Zone trip held after its cause went away");

  a_bi_filter: assert property (clk_en && cfg.test_pulse_en && !cfg_load && !bi_sync |=> !bi_filt [*2]) // [RL18]
    else $error("Binary input passed a short pulse");

  c_zone_trip:    cover property (clk_en && eval_tick ##1 status.zone_trip != '0);
  c_zone_blocked: cover property (clk_en && eval_tick ##1 status.zone_blocked != '0);
  c_phase_start:  cover property (status.phase_start && status.zone_trip != '0);
  c_sensor_fault: cover property (status.sensor_fault != '0);

endmodule : arcz_zone_logic

/* hdl/arcz_pkg.sv */
// Shared constants and carriers for the arc fault zone trip logic.
// Assumes a 100 MHz sys_clk and current magnitudes in units of 0.01 per-unit.
package arcz_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN     = 4;
  localparam int NUM_ZONE     = 4;
  localparam int NUM_PHASE    = 3;
  localparam int MAX_SENSORS  = 3;
  localparam int SAMPLE_W     = 16;
  localparam int LIMIT_W      = 12;
  localparam int UNIT_CNT_W   = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int EVAL_PERIOD_MS   = 5;
  localparam int EVAL_PERIOD_CYC  = EVAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int EVAL_CNT_W       = 20;
  localparam int PULSE_FILT_US    = 20;
  localparam int PULSE_FILT_CYC   = PULSE_FILT_US * 1000 / CLK_PERIOD_NS;
  localparam int FILT_CNT_W       = 12;
  localparam int REQ_SAMPLES      = 3;
  localparam int REQ_CNT_W        = 2;

  // ----------------------------------------------------------------
  // Limits in 0.01 per-unit steps
  // ----------------------------------------------------------------
  localparam logic [LIMIT_W-1:0] LIMIT_MIN     = 12'h005;
  localparam logic [LIMIT_W-1:0] LIMIT_MAX     = 12'hFA0;
  localparam logic [LIMIT_W-1:0] LIMIT_DEFAULT = 12'h078;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RES_NONE, RES_FIRST, RES_SECOND} arcz_res_src_t;

  typedef struct packed {
    logic [NUM_ZONE-1:0]                zone_en;
    logic [NUM_ZONE-1:0][NUM_CHAN-1:0]  light_map;
    logic [NUM_ZONE-1:0][NUM_CHAN-1:0]  press_map;
    logic [NUM_ZONE-1:0]                phase_en;
    logic [NUM_ZONE-1:0]                resid_en;
    logic [NUM_CHAN-1:0][1:0]           sensor_count;
    logic [UNIT_CNT_W-1:0]              unit_count;
    arcz_res_src_t                      res_src;
    logic [LIMIT_W-1:0]                 phase_limit;
    logic [LIMIT_W-1:0]                 resid_limit;
    logic                               test_pulse_en;
  } arcz_cfg_t;

  localparam arcz_cfg_t CFG_RESET = '{
    zone_en:       4'h0,
    light_map:     16'h0000,
    press_map:     16'h0000,
    phase_en:      4'h0,
    resid_en:      4'h0,
    sensor_count:  8'h00,
    unit_count:    4'h0,
    res_src:       RES_NONE,
    phase_limit:   LIMIT_DEFAULT,
    resid_limit:   LIMIT_DEFAULT,
    test_pulse_en: 1'h0
  };

  typedef struct packed {
    logic [NUM_CHAN-1:0] light;
    logic [NUM_CHAN-1:0] pressure;
    logic                binary_in;
    logic                phase_start;
    logic                resid_start;
    logic                phase_blocked;
    logic                resid_blocked;
    logic [NUM_ZONE-1:0] zone_trip;
    logic [NUM_ZONE-1:0] zone_blocked;
    logic [NUM_CHAN-1:0] sensor_fault;
    logic                unit_fault;
  } arcz_stat_t;

  localparam arcz_stat_t STAT_RESET = '0;

endpackage : arcz_pkg

/* hdl/arcz_over_det.sv */
// One current channel comparator with a consecutive-sample qualifier.
// Assumes samples and their strobe come from logic on sys_clk.
`timescale 1ns/10ps
module arcz_over_det
(
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             clk_en,
  // Sample stream
  input  wire logic                             sample_valid,
  input  wire logic [arcz_pkg::SAMPLE_W-1:0]    sample,
  input  wire logic [arcz_pkg::LIMIT_W-1:0]     limit,
  // Result
  output      logic                             over
);

  logic [arcz_pkg::REQ_CNT_W-1:0] run_cnt;
  logic                           above;

  assign above = sample > {{(arcz_pkg::SAMPLE_W-arcz_pkg::LIMIT_W){1'b0}}, limit};

  // A single noisy sample must not start the stage, so a run is needed
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      run_cnt <= '0;
      over    <= 1'b0;
    end
    else if (clk_en && sample_valid)
    begin
      if (!above)
      begin
        run_cnt <= '0;
        over    <= 1'b0;
      end
      else if (run_cnt < arcz_pkg::REQ_CNT_W'(arcz_pkg::REQ_SAMPLES - 1))
      begin
        run_cnt <= run_cnt + 2'h1;
      end
      else
      begin
        over <= 1'b1;
      end
    end
  end

endmodule : arcz_over_det

/* dv/arcz_sensor_model.sv */
// Far-side model: arc sensors on four channels and a chain of remote units.
// Assumes the bench sets the requests just after a falling edge of sys_clk.
`timescale 1ns/10ps
module arcz_sensor_model
(
  // Clock
  input  wire logic            sys_clk,
  // Scenario requests
  input  wire logic [3:0]      light_req,
  input  wire logic [3:0]      press_req,
  input  wire logic [3:0][1:0] n_sens,
  input  wire logic [3:0]      n_units,
  input  wire logic            bi_level,
  input  wire logic            pulse_on,
  // Pins seen by the device
  output      logic [3:0]      light_pin,
  output      logic [3:0]      pressure_pin,
  output      logic            arc_card_binary_input,
  output      logic [3:0][1:0] sensor_detected,
  output      logic [3:0]      units_connected
);
  logic [4:0] pulse_cnt = 5'h00;
  logic [3:0] present;

  // An empty channel cannot report light or pressure
  always_comb
  begin
    for (int c = 0; c < 4; c++)
      present[c] = |n_sens[c];
  end
  assign light_pin       = light_req & present;
  assign pressure_pin    = press_req & present;
  assign sensor_detected = n_sens;
  assign units_connected = n_units;

  // Short periodic wiring test pulses, far too brief to be a real input
  always_ff @(posedge sys_clk)
    pulse_cnt <= pulse_cnt + 5'h01;
  assign arc_card_binary_input = bi_level | (pulse_on & (pulse_cnt < 5'h02));
endmodule : arcz_sensor_model

/* dv/arcz_zone_logic_tb_top.sv */
// Self-checking bench for the arc fault zone decision logic.
// Assumes a shortened evaluation period; expectations come from the bench model.
`timescale 1ns/10ps
module arcz_zone_logic_tb_top;
  localparam int EVAL = 20;
  logic                 sys_clk = 1'b0, sys_rst = 1'b1, cfg_load = 1'b0, sample_valid = 1'b0;
  logic                 clk_en = 1'b1, first_hi = 1'b1;
  logic                 bi_level = 1'b0, pulse_on = 1'b0, phase_block = 1'b0, resid_block = 1'b0;
  logic [3:0]           light_req = '0, press_req = '0, n_units = '0, zone_block = '0;
  logic [3:0][1:0]      n_sens = '0;
  logic [2:0][15:0]     phase_sample = '0;
  logic [15:0]          res_a = '0, res_b = '0;
  logic [2:0]           p_ov = '0;
  logic [1:0]           r_ov = '0;
  logic [31:0]          seed = 32'he718;
  arcz_pkg::arcz_cfg_t  cfg = arcz_pkg::CFG_RESET;
  arcz_pkg::arcz_stat_t status, e_mon;
  arcz_pkg::arcz_stat_t exp_q[$];
  logic [3:0]           light_pin, pressure_pin, units_connected;
  logic [3:0][1:0]      sensor_detected;
  logic                 arc_bi, ft_a, ft_b, eval_done;
  int                   n_fail = 0, compares = 0, cyc = 0, frz = 0, waited = 0;

  arcz_zone_logic #(.EVAL_CYC(EVAL)) i_arcz_zone_logic (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .cfg_load(cfg_load), .cfg_in(cfg), .light_pin(light_pin), .pressure_pin(pressure_pin),
    .arc_card_binary_input(arc_bi), .sensor_detected(sensor_detected), .units_connected(units_connected),
    .sample_valid(sample_valid), .phase_sample(phase_sample), .residual_current_first(res_a),
    .residual_current_second(res_b), .phase_block(phase_block), .resid_block(resid_block),
    .zone_block(zone_block), .status(status), .fast_trip_output_a(ft_a), .fast_trip_output_b(ft_b),
    .eval_done(eval_done));
  arcz_sensor_model i_arcz_sensor_model (.sys_clk(sys_clk), .light_req(light_req), .press_req(press_req),
    .n_sens(n_sens), .n_units(n_units), .bi_level(bi_level), .pulse_on(pulse_on), .light_pin(light_pin),
    .pressure_pin(pressure_pin), .arc_card_binary_input(arc_bi), .sensor_detected(sensor_detected),
    .units_connected(units_connected));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // A sample strictly above or at-or-below the limit
  function automatic logic [15:0] smp(input logic hi, input logic [11:0] lim);
    return hi ? 16'(lim) + 16'h0001 + 16'(rnd() % 500) : 16'(rnd() % (32'(lim) + 1));
  endfunction : smp

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", name, want, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Expected outputs of the evaluation that follows the current stimulus
  function automatic arcz_pkg::arcz_stat_t calc();
    arcz_pkg::arcz_stat_t e;
    logic                 pov, rov, hit, cur;
    e = '0;
    for (int c = 0; c < 4; c++)
    begin
      e.light[c]        = light_req[c] & (|n_sens[c]);
      e.pressure[c]     = press_req[c] & (|n_sens[c]);
      e.sensor_fault[c] = n_sens[c] != cfg.sensor_count[c];
    end
    e.binary_in = bi_level;
    e.unit_fault = n_units != cfg.unit_count;
    pov = first_hi & (|p_ov);
    rov = (cfg.res_src == arcz_pkg::RES_FIRST) ? r_ov[0] : (cfg.res_src == arcz_pkg::RES_SECOND) ? r_ov[1] : 1'b0;
    rov = rov & first_hi;
    e.phase_start   = pov & !phase_block;
    e.phase_blocked = pov & phase_block;
    e.resid_start   = rov & !resid_block;
    e.resid_blocked = rov & resid_block;
    for (int z = 0; z < 4; z++)
    begin
      hit = cfg.zone_en[z] & (|((e.light & cfg.light_map[z]) | (e.pressure & cfg.press_map[z])));
      cur = !(cfg.phase_en[z] | cfg.resid_en[z]) | (cfg.phase_en[z] & e.phase_start)
            | (cfg.resid_en[z] & e.resid_start);
      e.zone_blocked[z] = hit & cur & zone_block[z];
      e.zone_trip[z]    = hit & cur & !zone_block[z];
    end
    return e;
  endfunction : calc

  // ----------------------------------------------------------------
  // Clock, watchdog and result monitor
  // ----------------------------------------------------------------
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  always @(negedge sys_clk)
  begin
    if (eval_done === 1'b1 && exp_q.size() > 0)
    begin
      e_mon = exp_q.pop_front();
      chk("light", 32'(status.light), 32'(e_mon.light));
      chk("pressure", 32'(status.pressure), 32'(e_mon.pressure));
      chk("binary_in", 32'(status.binary_in), 32'(e_mon.binary_in));
      chk("phase_start", 32'(status.phase_start), 32'(e_mon.phase_start));
      chk("resid_start", 32'(status.resid_start), 32'(e_mon.resid_start));
      chk("phase_blocked", 32'(status.phase_blocked), 32'(e_mon.phase_blocked));
      chk("resid_blocked", 32'(status.resid_blocked), 32'(e_mon.resid_blocked));
      chk("zone_trip", 32'(status.zone_trip), 32'(e_mon.zone_trip));
      chk("zone_blocked", 32'(status.zone_blocked), 32'(e_mon.zone_blocked));
      chk("sensor_fault", 32'(status.sensor_fault), 32'(e_mon.sensor_fault));
      chk("unit_fault", 32'(status.unit_fault), 32'(e_mon.unit_fault));
      chk("fast_a", 32'(ft_a), 32'(e_mon.phase_start | e_mon.resid_start));
      chk("fast_b", 32'(ft_b), 32'(|e_mon.zone_trip));
    end
  end

  // ----------------------------------------------------------------
  // Stimulus: one random scenario per evaluation period
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int it = 0; it < 200; it++)
    begin
      waited = 0;
      do
      begin
        @(negedge sys_clk);
        waited++;
      end
      while (eval_done !== 1'b1);
      if (it > 0)
        chk("eval_period", 32'(4 + frz + waited), 32'(EVAL + frz));
      light_req   = 4'(rnd());
      press_req   = 4'(rnd());
      n_sens      = 8'(rnd());
      n_units     = 4'(rnd() % 3);
      phase_block = rnd() % 4 == 0;
      resid_block = rnd() % 4 == 0;
      zone_block  = 4'(rnd()) & 4'(rnd());
      p_ov        = 3'(rnd()) & 3'(rnd());
      r_ov        = 2'(rnd());
      first_hi    = rnd() % 4 != 0;
      // First pass keeps the reset configuration
      if (it > 0)
      begin
        cfg.zone_en       = 4'(rnd());
        cfg.light_map     = 16'(rnd());
        cfg.press_map     = 16'(rnd());
        cfg.phase_en      = 4'(rnd());
        cfg.resid_en      = 4'(rnd());
        cfg.sensor_count  = rnd() % 2 == 0 ? n_sens : 8'(rnd());
        cfg.unit_count    = rnd() % 2 == 0 ? n_units : 4'(rnd());
        cfg.res_src       = arcz_pkg::arcz_res_src_t'(rnd() % 3);
        cfg.phase_limit   = 12'(5 + rnd() % 3996);
        cfg.resid_limit   = 12'(5 + rnd() % 3996);
        cfg.test_pulse_en = rnd() % 3 == 0;
        cfg_load          = 1'b1;
      end
      pulse_on = cfg.test_pulse_en;
      bi_level = !cfg.test_pulse_en & rnd() % 2 == 0;
      @(negedge sys_clk);
      cfg_load = 1'b0;
      // Over needs three consecutive high samples; any low one clears it
      for (int i = 0; i < 3; i++)
      begin
        sample_valid = 1'b1;
        for (int p = 0; p < 3; p++)
          phase_sample[p] = smp(i == 2 ? p_ov[p] : (i == 1 || first_hi), cfg.phase_limit);
        res_a = smp(i == 2 ? r_ov[0] : (i == 1 || first_hi), cfg.resid_limit);
        res_b = smp(i == 2 ? r_ov[1] : (i == 1 || first_hi), cfg.resid_limit);
        @(negedge sys_clk);
      end
      sample_valid = 1'b0;
      // Frozen cycles must not count toward the evaluation period
      clk_en       = 1'b0;
      frz          = int'(1 + rnd() % 3);
      repeat (frz) @(negedge sys_clk);
      clk_en       = 1'b1;
      exp_q.push_back(calc());
    end
    do @(negedge sys_clk); while (eval_done !== 1'b1);
    // Let the monitor take the last result first
    @(posedge sys_clk);
    chk("queue_left", 32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule : arcz_zone_logic_tb_top
